// ---- hw/tzc_defines.svh ----
`ifndef TZC_DEFINES_SVH
`define TZC_DEFINES_SVH
// ****************************************
// register offsets on the word port
// ****************************************
`define TZC_OFS_CTRL0  3'h0
`define TZC_OFS_CTRL1  3'h1
`define TZC_OFS_CNTLO  3'h2
`define TZC_OFS_HOLDHI 3'h3
`define TZC_OFS_IRQ    3'h4
// ****************************************
// field positions
// ****************************************
`define TZC_C0_EN      7
`define TZC_C0_PAD     6
`define TZC_C0_OUT     5
`define TZC_C0_WIDE    4
`define TZC_IRQ_FLAG   0
`define TZC_IRQ_IE     1
// ****************************************
// reset values and limits
// ****************************************
`define TZC_CTRL_RST   8'h00
`define TZC_HOLD_RST   8'hFF
`define TZC_CNT_MAX    16'hFFFF
`endif

// ---- hw/tzc_pkg.sv ----
package tzc_pkg;
  typedef enum logic [2:0] {
    SRC_PIN     = 3'b000,
    SRC_PIN_INV = 3'b001,
    SRC_INSTR   = 3'b010,
    SRC_HFO     = 3'b011,
    SRC_LFO     = 3'b100,
    SRC_MFO     = 3'b101,
    SRC_SECONDARY_OSCILLATOR    = 3'b110,
    SRC_LC1     = 3'b111
  } tzc_src_type;

  typedef struct packed {
    logic       en;
    logic       wide;
    logic [3:0] ps;
  } tzc_ctrl0_type;

  typedef struct packed {
    tzc_src_type cs;
    logic        unsync;
    logic [3:0]  ckps;
  } tzc_ctrl1_type;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tzc_bus_type;
endpackage : tzc_pkg

// ---- hw/tzc_timer.sv ----
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "tzc_defines.svh"

// Overview of operation
// - synchronized input: counter halts while the device sleeps
// - unsynchronized input keeps counting in sleep, wakes device if enabled
// - 8-bit mode: event when low byte equals period value
// - 16-bit mode: event when count wraps from FFFF to zero
// - flag set once every postscale field plus one events
// - flag with enable raises interrupt request and sleep wake
// - timer output goes to peripherals and to a pin
// - output level readable at control zero bit 5
// - match pulse high one prescaled period per postscaled event
// - square-wave output toggles on each match pulse rise
// - control zero bit 7 enables module, zero holds it idle
// - control zero bit 4 selects 16-bit versus 8-bit
// - control zero bits 3..0 divide events by n plus one
// - control one bits 7..5 pick the clock source
// - control one bit 4 set keeps the counter running in sleep
// - control one bits 3..0 prescale by two to the n
// - control zero bit 6 always reads zero
// - all control bits reset to zero
// - one byte holding register reaches the high count byte
// - 8-bit match clears low byte, reloads period buffer
// - 16-bit low byte read latches high count byte
// - 16-bit low byte write loads high byte from holding
// - scalers cleared by low write, control writes, reset
module tzc_timer
  import tzc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire tzc_bus_type bus_req,
  input  wire logic        sleep_mode,
  input  wire logic        external_clock_pin_input,
  input  wire logic        high_freq_internal_osc,
  input  wire logic        low_freq_internal_osc,
  input  wire logic        mid_freq_internal_osc,
  input  wire logic        secondary_oscillator,
  input  wire logic        logic_cell_one_output,
  output logic [7:0]       rd_data,
  output logic             match_pulse_out,
  output logic             timer_out,
  output logic             irq_req,
  output logic             wake_req
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic presc_hit(
    input logic [14:0] c,
    input logic [3:0]  n
  );
    logic [15:0] m;
    m = (16'h0001 << n) - 16'h0001;
    return (c & m[14:0]) == m[14:0];
  endfunction : presc_hit

  function automatic logic is_wr(
    input tzc_bus_type b,
    input logic [2:0]  a
  );
    return b.wr && (b.addr == a);
  endfunction : is_wr

  // ****************************************
  // state
  // ****************************************
  tzc_ctrl0_type ctrl0_reg;
  tzc_ctrl1_type ctrl1_reg;
  logic [15:0]   cnt_reg;
  logic [7:0]    hold_hi_reg;
  logic [7:0]    period_reg;
  logic [14:0]   presc_reg;
  logic [3:0]    post_reg;
  logic          flag_reg;
  logic          ie_reg;
  logic [7:0]    meta_reg;
  logic [7:0]    sync_reg;
  logic [7:0]    prev_reg;

  logic       wr_c0;
  logic       wr_c1;
  logic       wr_lo;
  logic       wr_hi;
  logic       wr_irq;
  logic       rd_lo;
  logic       scal_clr;
  logic       run;
  logic [7:0] src_vec;
  logic [7:0] rise;
  logic       src_edge;
  logic       presc_tick;
  logic       lo_match;
  logic       cnt_event;
  logic       post_ev;
  logic [7:0] rd_mux;

  assign wr_c0  = is_wr(bus_req, `TZC_OFS_CTRL0);
  assign wr_c1  = is_wr(bus_req, `TZC_OFS_CTRL1);
  assign wr_lo  = is_wr(bus_req, `TZC_OFS_CNTLO);
  assign wr_hi  = is_wr(bus_req, `TZC_OFS_HOLDHI);
  assign wr_irq = is_wr(bus_req, `TZC_OFS_IRQ);
  assign rd_lo  = bus_req.rd && (bus_req.addr == `TZC_OFS_CNTLO);
  assign scal_clr = wr_lo || wr_c0 || wr_c1;

  // ****************************************
  // clock source selection
  // ****************************************
  // every source but the instruction clock is brought in through two flops, also in unsync mode:
  // the block has one clock, so unsync only changes the sleep behaviour
  assign src_vec = {logic_cell_one_output, secondary_oscillator,
                    mid_freq_internal_osc, low_freq_internal_osc,
                    high_freq_internal_osc, 1'b0,
                    ~external_clock_pin_input,
                    external_clock_pin_input};

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 8'h00;
      sync_reg <= 8'h00;
      prev_reg <= 8'h00;
    end else begin
      meta_reg <= src_vec;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign rise = sync_reg & ~prev_reg;
  // the instruction clock source ticks every cycle
  assign src_edge = (ctrl1_reg.cs == SRC_INSTR) ? 1'b1
                  : rise[ctrl1_reg.cs];
  // sync mode halts in sleep, unsync keeps running
  assign run = ctrl0_reg.en
            && (!sleep_mode || ctrl1_reg.unsync);
  assign presc_tick = run && src_edge
                   && presc_hit(presc_reg, ctrl1_reg.ckps);

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl0_reg <= tzc_ctrl0_type'(6'(`TZC_CTRL_RST));
    end else if (wr_c0) begin
      ctrl0_reg.en   <= bus_req.wdata[`TZC_C0_EN];
      ctrl0_reg.wide <= bus_req.wdata[`TZC_C0_WIDE];
      ctrl0_reg.ps   <= bus_req.wdata[3:0];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl1_reg <= tzc_ctrl1_type'(`TZC_CTRL_RST);
    end else if (wr_c1) begin
      ctrl1_reg <= tzc_ctrl1_type'(bus_req.wdata);
    end
  end

  // ****************************************
  // prescaler and postscaler
  // ****************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      presc_reg <= 15'h0000;
    end else if (scal_clr || !ctrl0_reg.en) begin
      presc_reg <= 15'h0000;
    end else if (run && src_edge) begin
      presc_reg <= presc_reg + 15'h0001;
    end
  end

  assign lo_match  = cnt_reg[7:0] == period_reg;
  assign cnt_event = presc_tick && !wr_lo
                  && (ctrl0_reg.wide ? (cnt_reg == `TZC_CNT_MAX)
                                     : lo_match);
  assign post_ev = cnt_event && (post_reg == ctrl0_reg.ps);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      post_reg <= 4'h0;
    end else if (scal_clr) begin
      post_reg <= 4'h0;
    end else if (cnt_event) begin
      post_reg <= post_ev ? 4'h0 : post_reg + 4'h1;
    end
  end

  // ****************************************
  // count and holding registers
  // ****************************************
  // a bus write wins over a same-cycle tick, so software loads are exact
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 16'h0000;
    end else if (wr_lo) begin
      cnt_reg[7:0] <= bus_req.wdata;
      if (ctrl0_reg.wide) begin
        cnt_reg[15:8] <= hold_hi_reg;
      end
    end else if (presc_tick) begin
      if (ctrl0_reg.wide) begin
        cnt_reg <= cnt_reg + 16'h0001;
      end else if (lo_match) begin
        cnt_reg[7:0] <= 8'h00;
      end else begin
        cnt_reg[7:0] <= cnt_reg[7:0] + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hold_hi_reg <= `TZC_HOLD_RST;
    end else if (wr_hi) begin
      hold_hi_reg <= bus_req.wdata;
    end else if (rd_lo && ctrl0_reg.wide) begin
      hold_hi_reg <= cnt_reg[15:8];
    end
  end

  // a new period only takes effect at the next match
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      period_reg <= `TZC_HOLD_RST;
    end else if (cnt_event && !ctrl0_reg.wide) begin
      period_reg <= hold_hi_reg;
    end
  end

  // ****************************************
  // flag and requests
  // ****************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      flag_reg <= 1'b0;
    end else if (post_ev) begin
      flag_reg <= 1'b1;
    end else if (wr_irq && !bus_req.wdata[`TZC_IRQ_FLAG]) begin
      flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ie_reg <= 1'b0;
    end else if (wr_irq) begin
      ie_reg <= bus_req.wdata[`TZC_IRQ_IE];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_req  <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      irq_req  <= flag_reg && ie_reg;
      wake_req <= flag_reg && ie_reg && sleep_mode;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // pulse spans from the event to the next prescaled tick
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      match_pulse_out <= 1'b0;
    end else if (post_ev) begin
      match_pulse_out <= 1'b1;
    end else if (presc_tick || !ctrl0_reg.en) begin
      match_pulse_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      timer_out <= 1'b0;
    end else if (post_ev) begin
      timer_out <= ~timer_out;
    end
  end

  // ****************************************
  // register read port
  // ****************************************
  always_comb begin
    case (bus_req.addr)
      `TZC_OFS_CTRL0:  rd_mux = {ctrl0_reg.en, 1'b0, timer_out,
                                 ctrl0_reg.wide,
                                 ctrl0_reg.ps};
      `TZC_OFS_CTRL1:  rd_mux = ctrl1_reg;
      `TZC_OFS_CNTLO:  rd_mux = cnt_reg[7:0];
      `TZC_OFS_HOLDHI: rd_mux = hold_hi_reg;
      `TZC_OFS_IRQ:    rd_mux = {6'h00, ie_reg, flag_reg};
      default:         rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= bus_req.rd ? rd_mux : 8'h00;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  flag_hold_a: assert property (
    flag_reg && !wr_irq |=> flag_reg)
    else $error("flag dropped without clear");

  low_match_a: assert property (
    !ctrl0_reg.wide && presc_tick && lo_match && !wr_lo
    |=> cnt_reg[7:0] == 8'h00)
    else $error("low byte not cleared on match");

  wrap_a: assert property (
    ctrl0_reg.wide && cnt_event |=> cnt_reg == 16'h0000
    && ($past(post_reg) != $past(ctrl0_reg.ps) || flag_reg))
    else $error("wrap mishandled");

  toggle_a: assert property (
    post_ev |=> timer_out != $past(timer_out) && match_pulse_out)
    else $error("output did not toggle");

  status_bit_a: assert property (
    bus_req.rd && bus_req.addr == `TZC_OFS_CTRL0
    |=> rd_data[5] == $past(timer_out) && !rd_data[6])
    else $error("status bit wrong");

  disable_a: assert property (
    !ctrl0_reg.en && !wr_lo |=> $stable(cnt_reg) && presc_reg == 15'h0000)
    else $error("disabled timer moved");

  sleep_halt_a: assert property (
    sleep_mode && !ctrl1_reg.unsync && !wr_lo |=> $stable(cnt_reg))
    else $error("sync timer ran in sleep");

  scaler_clear_a: assert property (
    wr_c0 || wr_c1 |=> presc_reg == 15'h0000 && post_reg == 4'h0)
    else $error("scalers not cleared");

  latch_hi_a: assert property (
    rd_lo && ctrl0_reg.wide && !wr_hi
    |=> hold_hi_reg == $past(cnt_reg[15:8]))
    else $error("high byte not latched");

  irq_a: assert property (
    flag_reg && ie_reg |=> irq_req && wake_req == $past(sleep_mode))
    else $error("interrupt request missing");

  post_c: cover property (post_ev && ctrl0_reg.ps == 4'h3);
  wrap_c: cover property (ctrl0_reg.wide && cnt_event);
  match_c: cover property (!ctrl0_reg.wide && cnt_event);
  wake_c: cover property (sleep_mode && ctrl1_reg.unsync && wake_req);

endmodule : tzc_timer
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "tzc_defines.svh"
module tb
  import tzc_pkg::*;
;
  logic        clk_sys;
  logic        arst_n;
  tzc_bus_type bus_req;
  logic        sleep_mode;
  logic [7:0]  ext;
  logic [7:0]  rd_data;
  logic        match_pulse_out;
  logic        timer_out;
  logic        irq_req;
  logic        wake_req;
  logic [31:0] lfsr;
  logic        texp;
  logic [7:0]  v;
  int          err_total;
  int          num_checks;
  int          i;
  int          c;
  int          k;
  int          ps;
  int          ck;
  int          p;
  int          n;

  tzc_timer dut (
    .clk_sys                  (clk_sys),
    .arst_n                   (arst_n),
    .bus_req                  (bus_req),
    .sleep_mode               (sleep_mode),
    .external_clock_pin_input (ext[0] ^ ext[1]),
    .high_freq_internal_osc   (ext[3]),
    .low_freq_internal_osc    (ext[4]),
    .mid_freq_internal_osc    (ext[5]),
    .secondary_oscillator     (ext[6]),
    .logic_cell_one_output    (ext[7]),
    .rd_data                  (rd_data),
    .match_pulse_out          (match_pulse_out),
    .timer_out                (timer_out),
    .irq_req                  (irq_req),
    .wake_req                 (wake_req)
  );

  always #2 clk_sys = ~clk_sys;

  // ****
  // helpers
  // ****
  function automatic int cyc(input int s, input int q, input int b);
    return (s + 1) * (q + 1) * (1 << b);
  endfunction : cyc

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic rnd(input int m, output int r);
    lfsr = lfsr_next(lfsr);
    r = int'(lfsr % m);
  endtask : rnd

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %0h seen %0h", w, e, g);
    end
  endtask : chk

  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus_req <= '{a, d, 1'b0, 1'b0};
  endtask : bus_wr

  task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus_req <= '{a, 8'h00, 1'b0, 1'b0};
    #1;
    d = rd_data;
  endtask : bus_rd

  task automatic rchk(input string w, input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    bus_rd(a, d);
    chk(w, {24'h0, e}, {24'h0, d});
  endtask : rchk

  // edges up to the next output change; bounded so a stuck timer ends
  task automatic wait_tog(input int lim, output int cnt);
    logic t;
    t = timer_out;
    cnt = 0;
    do begin
      @(posedge clk_sys);
      #1;
      cnt++;
    end while (timer_out === t && cnt < lim);
    if (timer_out === t) begin
      err_total++;
      $display("BAD toggle expected within %0d seen none", lim);
    end
    texp = ~texp;
  endtask : wait_tog

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  // ****
  // tests
  // ****
  initial begin
    clk_sys = 1'b0;
    arst_n = 1'b0;
    bus_req = '0;
    sleep_mode = 1'b0;
    ext = 8'h00;
    texp = 1'b0;
    lfsr = 32'h00014F4C;
    err_total = 0;
    num_checks = 0;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    rchk("ctrl0", `TZC_OFS_CTRL0, 8'h00);
    rchk("ctrl1", `TZC_OFS_CTRL1, 8'h00);
    rchk("low", `TZC_OFS_CNTLO, 8'h00);
    rchk("hold", `TZC_OFS_HOLDHI, 8'hFF);
    rchk("unmapped", 3'h5, 8'h00);
    bus_wr(`TZC_OFS_CTRL0, 8'hFF);
    rchk("ctrl0 pad", `TZC_OFS_CTRL0, 8'h9F);
    $display("test registers done");
    for (c = 0; c < 8; c++) begin
      if (c != 2) begin
        @(posedge clk_sys);
        ext[c] <= (c == 1);
        bus_wr(`TZC_OFS_CTRL1, {3'(c), 5'h00});
        bus_wr(`TZC_OFS_CTRL0, 8'h90);
        bus_wr(`TZC_OFS_HOLDHI, 8'h00);
        bus_wr(`TZC_OFS_CNTLO, 8'h00);
        rnd(5, k);
        k += 3;
        // source high and low for 3 cycles, above the 2-cycle minimum
        repeat (2 * k) begin
          repeat (3) @(posedge clk_sys);
          ext[c] <= ~ext[c];
        end
        repeat (6) @(posedge clk_sys);
        rchk("source count", `TZC_OFS_CNTLO, 8'(k));
        ext[c] <= 1'b0;
      end
    end
    $display("test sources done");
    bus_wr(`TZC_OFS_IRQ, 8'h02);
    for (i = 0; i < 4; i++) begin
      rnd(4, ps);
      rnd(3, ck);
      rnd(8, p);
      p += 5;
      if (i == 0) begin
        ps = 15;
      end
      bus_wr(`TZC_OFS_CTRL1, {4'h4, 4'(ck)});
      bus_wr(`TZC_OFS_HOLDHI, 8'(p));
      bus_wr(`TZC_OFS_CTRL0, {4'h8, 4'(ps)});
      wait_tog(20000, n);
      chk("pulse", 1, match_pulse_out);
      wait_tog(20000, n);
      chk("interval", cyc(ps, p, ck), n);
      @(posedge clk_sys);
      #1;
      chk("irq", 1, irq_req);
      bus_wr(`TZC_OFS_IRQ, 8'h02);
      @(posedge clk_sys);
      #1;
      chk("irq clr", 0, irq_req);
      wait_tog(20000, n);
      rchk("status", `TZC_OFS_CTRL0, {2'b10, texp, 1'b0, 4'(ps)});
    end
    bus_wr(`TZC_OFS_CTRL0, 8'h00);
    bus_rd(`TZC_OFS_CNTLO, v);
    repeat (10) @(posedge clk_sys);
    rchk("idle", `TZC_OFS_CNTLO, v);
    rchk("flag", `TZC_OFS_IRQ, 8'h03);
    bus_wr(`TZC_OFS_IRQ, 8'h03);
    rchk("flag kept", `TZC_OFS_IRQ, 8'h03);
    bus_wr(`TZC_OFS_IRQ, 8'h02);
    rchk("flag clr", `TZC_OFS_IRQ, 8'h02);
    $display("test period done");
    bus_wr(`TZC_OFS_HOLDHI, 8'h28);
    bus_wr(`TZC_OFS_CTRL1, 8'h40);
    bus_wr(`TZC_OFS_CTRL0, 8'h80);
    @(posedge clk_sys);
    sleep_mode <= 1'b1;
    bus_rd(`TZC_OFS_CNTLO, v);
    repeat (10) @(posedge clk_sys);
    rchk("sync sleep", `TZC_OFS_CNTLO, v);
    bus_wr(`TZC_OFS_CTRL1, 8'h50);
    wait_tog(2000, n);
    @(posedge clk_sys);
    #1;
    chk("wake", 1, wake_req);
    @(posedge clk_sys);
    sleep_mode <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("awake", 0, wake_req);
    $display("test sleep done");
    bus_wr(`TZC_OFS_CTRL0, 8'h10);
    bus_wr(`TZC_OFS_HOLDHI, 8'hFF);
    bus_wr(`TZC_OFS_CNTLO, 8'hFA);
    bus_wr(`TZC_OFS_HOLDHI, 8'h00);
    rchk("low", `TZC_OFS_CNTLO, 8'hFA);
    rchk("latched", `TZC_OFS_HOLDHI, 8'hFF);
    bus_wr(`TZC_OFS_CTRL1, 8'h40);
    bus_wr(`TZC_OFS_CTRL0, 8'h90);
    wait_tog(12, n);
    // a full wrap is long but only this shows the 16-bit period
    wait_tog(70000, n);
    chk("wrap", 65536, n);
    $display("test wide done");
    conclude();
  end

  initial begin
    #400000;
    err_total++;
    $display("BAD watchdog expected end seen timeout");
    conclude();
  end
endmodule : tb
`default_nettype wire
